// [fcv_defines.svh]
`ifndef FCV_DEFINES_SVH
`define FCV_DEFINES_SVH

// Register map
`define CAL_VALUE_OFFSET 8'h00

// Field positions inside the calibration value word
`define RATIO_ERROR_MSB 31
`define RATIO_ERROR_LSB 16
`define COARSE_MSB 15
`define COARSE_LSB 10
`define FINE_MSB 9
`define FINE_LSB 0

// Reset values
`define RATIO_ERROR_RESET 16'h0000
`define COARSE_RESET 6'h00
`define FINE_RESET 10'h000
`define READ_IDLE 32'h0000_0000

`endif

// [fcv_pkg.sv]
`default_nettype none

package fcv_pkg;

  // Loop operating mode, one-hot
  typedef enum logic [1:0]
  {
    OPEN_LOOP_ST = 2'b01,
    CLOSED_LOOP_ST = 2'b10
  } loop_state_type;

  typedef logic [5:0] coarse_type;
  typedef logic [9:0] fine_type;
  typedef logic signed [15:0] ratio_error_type;

endpackage

`default_nettype wire

// [cal_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Carries trim field updates between the bus side and the field store
interface cal_if;
  logic closed;
  logic sw_we;
  fcv_pkg::coarse_type sw_coarse;
  fcv_pkg::fine_type sw_fine;
  logic loop_we;
  fcv_pkg::coarse_type loop_coarse;
  fcv_pkg::fine_type loop_fine;
  fcv_pkg::coarse_type coarse;
  fcv_pkg::fine_type fine;

  modport ctrl
  (
    output closed, sw_we, sw_coarse, sw_fine, loop_we, loop_coarse, loop_fine,
    input coarse, fine
  );
  modport store
  (
    input closed, sw_we, sw_coarse, sw_fine, loop_we, loop_coarse, loop_fine,
    output coarse, fine
  );
endinterface

`default_nettype wire

// [cal_field_store.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcv_defines.svh"

module cal_field_store
(
  input wire logic clk,
  input wire logic rst_b,
  cal_if.store cal
);

  logic take_sw;
  logic take_loop;
  fcv_pkg::coarse_type coarse_reg;
  fcv_pkg::coarse_type coarse_next;
  fcv_pkg::fine_type fine_reg;
  fcv_pkg::fine_type fine_next;

  // Owner selection: software in open loop, loop logic in closed loop
  // closed writes dropped
  assign take_sw = cal.sw_we & ~cal.closed;
  assign take_loop = cal.loop_we & cal.closed;
  assign coarse_next = take_loop ? cal.loop_coarse : (take_sw ? cal.sw_coarse : coarse_reg);
  assign fine_next = take_loop ? cal.loop_fine : (take_sw ? cal.sw_fine : fine_reg);

  // Trim storage
  // fields reset to zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      coarse_reg <= `COARSE_RESET;
      fine_reg <= `FINE_RESET;
    end
    else
    begin
      coarse_reg <= coarse_next;
      fine_reg <= fine_next;
    end
  end

  assign cal.coarse = coarse_reg;
  assign cal.fine = fine_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_coarse_sw_write: assert property (
    (!cal.closed && cal.sw_we) |=> (cal.coarse == $past(cal.sw_coarse)))
    else $error("coarse not taken from open-loop write");

  a_fine_sw_write: assert property (
    (!cal.closed && cal.sw_we) |=> (cal.fine == $past(cal.sw_fine)))
    else $error("fine not taken from open-loop write");

  a_loop_owns_fields: assert property (
    (cal.closed && cal.loop_we) |=>
      (cal.coarse == $past(cal.loop_coarse)) && (cal.fine == $past(cal.loop_fine)))
    else $error("loop update not stored in closed loop");

  a_closed_write_ignored: assert property (
    (cal.closed && cal.sw_we && !cal.loop_we) |=> ($stable(cal.coarse) && $stable(cal.fine)))
    else $error("software write changed trim in closed loop");

endmodule

`default_nettype wire

// [fll_calibration_value.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fcv_defines.svh"

module fll_calibration_value
#(
  parameter int ADDR_W = 8
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic LOOP_SELECT,
  input wire logic MEAS_DONE,
  input wire logic [15:0] MEAS_ERROR,
  input wire logic LOOP_TRIM_WE,
  input wire logic [5:0] LOOP_COARSE,
  input wire logic [9:0] LOOP_FINE,
  output logic [5:0] OSC_COARSE,
  output logic [9:0] OSC_FINE,
  output logic [15:0] RATIO_ERROR,
  output logic CLOSED_LOOP
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode tracking

  fcv_pkg::loop_state_type state_reg;
  fcv_pkg::loop_state_type state_next;
  logic closed;

  // Mode follows the loop selection bit from the control register
  always_comb
  begin
    case (LOOP_SELECT)
      1'b0: state_next = fcv_pkg::OPEN_LOOP_ST;
      1'b1: state_next = fcv_pkg::CLOSED_LOOP_ST;
      default: state_next = fcv_pkg::OPEN_LOOP_ST;
    endcase
  end

  // Registered so that owner switch and field writes align on one edge
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      state_reg <= fcv_pkg::OPEN_LOOP_ST;
    else
      state_reg <= state_next;
  end

  assign closed = (state_reg == fcv_pkg::CLOSED_LOOP_ST);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic hit;
  logic wr_hit;
  logic rd_hit;

  // Single word register, anything else reads zero
  assign hit = (ADDR == ADDR_W'(`CAL_VALUE_OFFSET));
  assign wr_hit = WR & hit;
  assign rd_hit = RD & hit;

  ////////////////////////////////////////////////////////////////////////////
  // Trim field store

  cal_if cal_bus();

  // Field slices of the write word
  assign cal_bus.closed = closed;
  assign cal_bus.sw_we = wr_hit;
  assign cal_bus.sw_coarse = WDATA[`COARSE_MSB:`COARSE_LSB];
  assign cal_bus.sw_fine = WDATA[`FINE_MSB:`FINE_LSB];
  assign cal_bus.loop_we = LOOP_TRIM_WE;
  assign cal_bus.loop_coarse = LOOP_COARSE;
  assign cal_bus.loop_fine = LOOP_FINE;

  cal_field_store u_store
  (
    .clk(CLK),
    .rst_b(RST_B),
    .cal(cal_bus.store)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Ratio error capture

  logic [15:0] ratio_error_reg;
  logic [15:0] ratio_error_next;
  logic take_meas;

  assign take_meas = MEAS_DONE & closed;
  assign ratio_error_next = take_meas ? MEAS_ERROR : ratio_error_reg;

  // Read-only for software; stale value kept across open loop
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      ratio_error_reg <= `RATIO_ERROR_RESET;
    else
      ratio_error_reg <= ratio_error_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] cal_word;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Word assembly from live fields
  assign cal_word = {ratio_error_reg, cal_bus.coarse, cal_bus.fine};
  assign rdata_next = rd_hit ? cal_word : `READ_IDLE;

  // Data valid only in the cycle after the strobe
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      rdata_reg <= `READ_IDLE;
    else
      rdata_reg <= rdata_next;
  end

  // Outputs
  assign RDATA = rdata_reg;
  assign OSC_COARSE = cal_bus.coarse;
  assign OSC_FINE = cal_bus.fine;
  assign RATIO_ERROR = ratio_error_reg;
  assign CLOSED_LOOP = closed;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  sequence s_closed_meas;
    closed && MEAS_DONE;
  endsequence

  sequence s_cal_read;
    RD && hit;
  endsequence

  // Software write accepted while the loop is open
  sequence s_open_sw_write;
    !closed && WR && hit;
  endsequence

  // Software write arriving while the loop owns the trim
  sequence s_closed_sw_write;
    closed && WR && hit && !LOOP_TRIM_WE;
  endsequence

  // Loop trim update taken in closed loop
  sequence s_loop_trim;
    closed && LOOP_TRIM_WE;
  endsequence

  a_ratio_error_capture: assert property (
    s_closed_meas |=> (RATIO_ERROR == $past(MEAS_ERROR))
      ##1 (RDATA[`RATIO_ERROR_MSB:`RATIO_ERROR_LSB] == $past(RATIO_ERROR, 1) || !$past(RD && hit)))
    else $error("ratio error not captured in closed loop");

  a_ratio_error_no_write: assert property (
    (WR && hit && !(closed && MEAS_DONE)) |=> $stable(RATIO_ERROR))
    else $error("software write reached ratio error field");

  a_ratio_error_open_hold: assert property (
    !closed |=> $stable(RATIO_ERROR))
    else $error("ratio error changed in open loop");

  a_read_word: assert property (
    s_cal_read |=> (RDATA == {$past(RATIO_ERROR), $past(OSC_COARSE), $past(OSC_FINE)}))
    else $error("read word does not match fields");

  a_read_idle: assert property (
    !(RD && hit) |=> (RDATA == `READ_IDLE))
    else $error("read data not zero outside read cycle");

  a_closed_no_write: assert property (
    s_closed_sw_write |=> $stable(OSC_COARSE) && $stable(OSC_FINE))
    else $error("closed-loop software write altered trim");

  a_open_loop_ignore: assert property (
    (!closed && LOOP_TRIM_WE && !(WR && hit)) |=> $stable(OSC_COARSE) && $stable(OSC_FINE))
    else $error("loop update applied in open loop");

  a_loop_trim_out: assert property (
    s_loop_trim |=> (OSC_FINE == $past(LOOP_FINE)) && (OSC_COARSE == $past(LOOP_COARSE)))
    else $error("loop trim not driven to oscillator");

  a_reset_zero: assert property (
    $rose(RST_B) |-> (RATIO_ERROR == `RATIO_ERROR_RESET) && (OSC_COARSE == `COARSE_RESET)
      && (OSC_FINE == `FINE_RESET) && !CLOSED_LOOP)
    else $error("fields not zero after reset");

  a_mode_follow: assert property (
    1'b1 |=> (CLOSED_LOOP == $past(LOOP_SELECT)))
    else $error("mode not tracking loop select");

  a_open_write: assert property (
    s_open_sw_write |=> (OSC_FINE == $past(WDATA[`FINE_MSB:`FINE_LSB]))
      && (OSC_COARSE == $past(WDATA[`COARSE_MSB:`COARSE_LSB])))
    else $error("open-loop write not applied");

  a_write_readback: assert property (
    s_open_sw_write ##1 s_cal_read |=>
      (RDATA[`FINE_MSB:`FINE_LSB] == $past(WDATA[`FINE_MSB:`FINE_LSB], 2)))
    else $error("open-loop write not returned by next read");

endmodule

`default_nettype wire

// [fll_calibration_value_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module fll_calibration_value_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic meas = 1'b0;
  logic [15:0] err = 16'h0000;
  logic trim = 1'b0;
  logic [5:0] lc = 6'h00;
  logic [9:0] lf = 10'h000;
  logic [31:0] rdata;
  logic [5:0] coarse;
  logic [9:0] fine;
  logic [15:0] ratio;
  logic closed;
  logic [31:0] got;
  int errors = 0;
  int n_tests = 0;

  fll_calibration_value #(.ADDR_W(8)) uut
  (
    .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .LOOP_SELECT(sel), .MEAS_DONE(meas), .MEAS_ERROR(err),
    .LOOP_TRIM_WE(trim), .LOOP_COARSE(lc), .LOOP_FINE(lf),
    .OSC_COARSE(coarse), .OSC_FINE(fine), .RATIO_ERROR(ratio), .CLOSED_LOOP(closed)
  );

  // 4 ns period
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, shared by the tests and the watchdog
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; extra edge at the end keeps strobes from being reassigned
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  // Write then read with no gap, as the bus allows
  task automatic wr_rd_reg(input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdata;
    @(posedge clk);
  endtask

  // One loop-side event, settled before return
  task automatic loop_ev(input logic m, input logic [15:0] e, input logic t,
                         input logic [5:0] c, input logic [9:0] f);
    meas <= m;
    err <= e;
    trim <= t;
    lc <= c;
    lf <= f;
    @(posedge clk);
    meas <= 1'b0;
    trim <= 1'b0;
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the roughly 60 cycles of the tests
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check({ratio, coarse, fine}, 32'h0000_0000);
    rd_reg(8'h00, got);
    check(got, 32'h0000_0000);
    wr_reg(8'h00, 32'hFFFF_FFFF);
    rd_reg(8'h00, got);
    check(got, 32'h0000_FFFF);
    check({16'h0000, coarse, fine}, 32'h0000_FFFF);
    // Back-to-back write and read; bits 31:16 stay unwritable
    wr_rd_reg(8'h00, 32'hFFFF_5A5A, got);
    check(got, 32'h0000_5A5A);
    wr_reg(8'h00, 32'h1234_A5C3);
    check({26'h0, coarse}, 32'h0000_0029);
    check({22'h0, fine}, 32'h0000_01C3);
    // Unmapped address: write dropped, read gives zero
    wr_reg(8'h04, 32'h0000_0000);
    rd_reg(8'h04, got);
    check(got, 32'h0000_0000);
    rd_reg(8'h00, got);
    check(got, 32'h0000_A5C3);
    // Loop events while open must change nothing
    loop_ev(1'b1, 16'h7FFF, 1'b1, 6'h15, 10'h2AA);
    check({ratio, coarse, fine}, 32'h0000_A5C3);
    sel <= 1'b1;
    @(posedge clk);
    loop_ev(1'b1, 16'h8001, 1'b0, 6'h00, 10'h000);
    check({16'h0, ratio}, 32'h0000_8001);
    loop_ev(1'b1, 16'h7FFE, 1'b1, 6'h15, 10'h2AA);
    rd_reg(8'h00, got);
    check(got, {16'h7FFE, 6'h15, 10'h2AA});
    // Software write while closed is ignored
    wr_reg(8'h00, 32'h0000_FFFF);
    rd_reg(8'h00, got);
    check(got, {16'h7FFE, 6'h15, 10'h2AA});
    check({31'h0, closed}, 32'h0000_0001);
    sel <= 1'b0;
    @(posedge clk);
    loop_ev(1'b1, 16'h1234, 1'b0, 6'h00, 10'h000);
    wr_reg(8'h00, 32'h0000_0401);
    rd_reg(8'h00, got);
    check(got, 32'h7FFE_0401);
    // Reset in mid-run clears every field
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_reg(8'h00, got);
    check(got, 32'h0000_0000);
    check({15'h0, closed, coarse, fine}, 32'h0000_0000);
    end_of_test();
  end
endmodule

`default_nettype wire
